// ---- hdl/acs_regs.svh ----
/*
 * Offsets, field positions and timing figures of the conversion sequencer.
 * Assumes: included by bare name; definitions only.
 */
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ==========================================================
// timing
`define ACS_CLK_PERIOD_NS   40
`define ACS_T_OVERHEAD_NS   6000
`define ACS_T_CHANNEL_NS    6000
`define ACS_T_SETTLE_US     500
`define ACS_NS_PER_US       1000

// ==========================================================
// device register offsets (results: channel k at base + 2k, msb first)
`define ACS_OFS_STATUS      8'h00
`define ACS_OFS_RESULT_BASE 8'h01
`define ACS_OFS_RESULT_LAST 8'h12
`define ACS_OFS_ADC_CONTROL 8'h30
`define ACS_OFS_IO_CONTROL  8'h31
`define ACS_OFS_CONVERT     8'h34
`define ACS_OFS_FUNC_CONFIG 8'h40

// ==========================================================
// device fields
`define ACS_ADC_CELL_SEL_HI 2
`define ACS_ADC_AUX         3
`define ACS_ADC_TS1         4
`define ACS_ADC_TS2         5
`define ACS_ADC_POWER       6
`define ACS_IO_TS1_SWITCH   0
`define ACS_IO_TS2_SWITCH   1
`define ACS_FN_AUX_SOURCE   4
`define ACS_FN_AUX_REF      6
`define ACS_SOFT_START_BIT_SOFT_START 0
`define ACS_ST_BUSY         0
`define ACS_ST_DONE         1

// ==========================================================
// channel codes and result limit
`define ACS_CH_AUX          4'h0
`define ACS_CH_TS1          4'h7
`define ACS_CH_TS2          4'h8
`define ACS_POS_NONE        4'hf
`define ACS_POS_LAST        8
`define ACS_CELLS           6
`define ACS_RES_MAX         16'h3fff

// ==========================================================
// host controller offsets and fields
`define ACS_H_OFS_CTRL      8'h00
`define ACS_H_OFS_DEV_ADDR  8'h01
`define ACS_H_OFS_DEV_WDATA 8'h02
`define ACS_H_OFS_DEV_RDATA 8'h03
`define ACS_H_OFS_STATUS    8'h04
`define ACS_H_CTRL_HW_START 0
`define ACS_H_CTRL_DEV_WR   1
`define ACS_H_CTRL_DEV_RD   2

`endif

// ---- hdl/acs_pkg.sv ----
/*
 * Types shared by both ends of the conversion sequencer link.
 * Assumes: compiled before every other design file.
 */
package acs_pkg;
	// ==========================================================
	// types
	typedef logic [7:0]  acs_byte_t;
	typedef logic [3:0]  acs_chan_t;
	typedef logic [15:0] acs_raw_t;
	typedef enum logic [1:0] {
		ACS_IDLE     = 2'b00,
		ACS_SETTLE   = 2'b01,
		ACS_OVERHEAD = 2'b10,
		ACS_CONVERT  = 2'b11
	} acs_state_e;
	typedef enum logic [1:0] {
		ACS_H_IDLE   = 2'b00,
		ACS_H_CLEAR  = 2'b01,
		ACS_H_WAIT   = 2'b10
	} acs_pin_e;
endpackage : acs_pkg

// ---- hdl/acs_link_if.sv ----
/*
 * Link between host controller and monitor: start pin, data-ready pin and
 * the device register port.
 * Assumes: both ends on clk; the bench joins the two ends through this.
 */
`timescale 1ns/10ps
interface acs_link_if (
	input wire logic clk
);
	import acs_pkg::*;
	logic      host_start_out;     // host pin driver level
	logic      host_start_oe_n;    // low while host drives
	logic      start_in_host_side; // resolved pin level
	logic      done_out_host_side;
	acs_byte_t reg_addr;
	acs_byte_t reg_wdata;
	logic      reg_wr;
	logic      reg_rd;
	acs_byte_t reg_rdata;

	// ==========================================================
	// pin resolution: undriven pin falls to low through the pulldown
	assign start_in_host_side = host_start_oe_n ? 1'b0 : host_start_out;

	modport device (
		input  start_in_host_side,
		output done_out_host_side,
		input  reg_addr,
		input  reg_wdata,
		input  reg_wr,
		input  reg_rd,
		output reg_rdata
	);
	modport host (
		output host_start_out,
		output host_start_oe_n,
		input  done_out_host_side,
		output reg_addr,
		output reg_wdata,
		output reg_wr,
		output reg_rd,
		input  reg_rdata
	);
endinterface : acs_link_if

// ---- hdl/acs_sync3.sv ----
/*
 * Three-stage input synchroniser; the output moves once stages two and
 * three agree.
 * Assumes: async input, clk domain output.
 */
`timescale 1ns/10ps
module acs_sync3 (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic out;
	} acs_sync_s;
	acs_sync_s q;
	acs_sync_s next_q;

	// ==========================================================
	// stage one feeds only stage two, so metastability stays contained
	always_comb begin
		next_q = q;
		next_q.s1 = din;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		if (q.s2 == q.s3) begin
			next_q.out = q.s3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= next_q;
		end
	end

	assign dout = q.out;
endmodule : acs_sync3

// ---- hdl/acs_device.sv ----
/*
 * Monitor end: register file, start detection, channel sequencer, result
 * store and daisy-chained data-ready.
 * Assumes: analog mux and converter outside, driven by adc_* outputs and
 * returning adc_raw; done_in_north tied high on the top device.
 */
`timescale 1ns/10ps
`include "acs_regs.svh"

// What this block does
// - aux source picks external pair or brick
// - aux reference bit picks bandgap or regulator
// - brick source forces bandgap, ignores reference bit
// - thermistor channels use regulator reference
// - thermistor results clamped to 0..16383
// - thermistor needs enable and switch bits
// - start from pin or soft start bit
// - pin rising edge starts; host holds high
// - pin start also raised to north device
// - start converts every enabled channel in turn
// - soft bit ignored while pin is high
// - pulldown keeps unconnected start pin low
// - soft bit write-one only, self clears
// - software starts all devices by broadcast
// - done only after last result and north done
// - done drops at next cycle start
// - cell select converts cells 1 to n+1, at most cells 1 to 6
// - thermistor and aux enable bits add channels
// - 6 us overhead plus 6 us per channel
// - power bit keeps reference up; host waits
// - power bit clear adds 500 us settling
// - software uses manual mode below 10 ms
// - 14-bit results, msb at lower address
module acs_device #(
	parameter int SETTLE_CYCLES =
		(`ACS_T_SETTLE_US * `ACS_NS_PER_US + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS,
	parameter int CNT_W         = 14
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	acs_link_if.device       link,
	output logic             start_out_north,
	input  wire logic        done_in_north,
	output acs_pkg::acs_chan_t adc_channel,
	output logic             adc_aux_brick,
	output logic             adc_ref_regulator,
	output logic             adc_active,
	output logic             adc_power,
	output logic [1:0]       thermistor_switch,
	input  wire acs_pkg::acs_raw_t adc_raw
);
	import acs_pkg::*;

	localparam int OVH_CYC =
		(`ACS_T_OVERHEAD_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS;
	localparam int CH_CYC =
		(`ACS_T_CHANNEL_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS;

	typedef struct packed {
		acs_state_e       st;
		logic [CNT_W-1:0] cnt;
		logic [3:0]       pos;
		acs_chan_t        ch;
		logic             aux_brick;
		logic             ref_reg;
		logic             active;
		logic             pwr;
		acs_byte_t        adc_ctl;
		acs_byte_t        io_ctl;
		acs_byte_t        fn_cfg;
		logic             soft_start;
		logic             done;
		logic             done_out;
		logic             north;
		logic             pin_q;
		acs_byte_t        rdata;
		logic [8:0][13:0] res;
	} acs_dev_s;

	acs_dev_s q;
	acs_dev_s next_q;
	logic     pin_s;
	logic     north_done_s;

	// ==========================================================
	// pin synchronisers
	acs_sync3 u_pin_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  (link.start_in_host_side),
		.dout (pin_s)
	);
	acs_sync3 u_north_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  (done_in_north),
		.dout (north_done_s)
	);

	// ==========================================================
	// sequence helpers: positions 0-5 cells, 6 ts1, 7 ts2, 8 aux
	function automatic logic pos_enabled(input logic [3:0] p, input acs_byte_t ctl);
		logic en;
		en = 1'b0;
		if (p < 4'(`ACS_CELLS)) begin
			en = (p <= {1'b0, ctl[`ACS_ADC_CELL_SEL_HI:0]});
		end else if (p == 4'(`ACS_CELLS)) begin
			en = ctl[`ACS_ADC_TS1];
		end else if (p == 4'(`ACS_CELLS + 1)) begin
			en = ctl[`ACS_ADC_TS2];
		end else if (p == 4'(`ACS_POS_LAST)) begin
			en = ctl[`ACS_ADC_AUX];
		end
		return en;
	endfunction : pos_enabled

	function automatic logic [3:0] first_pos(input logic [3:0] from, input acs_byte_t ctl);
		logic [3:0] r;
		r = `ACS_POS_NONE;
		for (int i = `ACS_POS_LAST; i >= 0; i--) begin
			if (4'(i) >= from && pos_enabled(4'(i), ctl)) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : first_pos

	function automatic acs_chan_t pos_to_ch(input logic [3:0] p);
		acs_chan_t c;
		if (p < 4'(`ACS_CELLS)) begin
			c = p + 4'h1;
		end else if (p == 4'(`ACS_CELLS)) begin
			c = `ACS_CH_TS1;
		end else if (p == 4'(`ACS_CELLS + 1)) begin
			c = `ACS_CH_TS2;
		end else begin
			c = `ACS_CH_AUX;
		end
		return c;
	endfunction : pos_to_ch

	// ==========================================================
	// next state
	always_comb begin
		logic       pin_rise;
		logic [3:0] nxt;
		acs_chan_t  c;
		acs_byte_t  a;
		logic [3:0] k;
		pin_rise = 1'b0;
		nxt = '0;
		c = '0;
		a = '0;
		k = '0;
		next_q = q;
		next_q.rdata = '0;
		next_q.pin_q = pin_s;
		pin_rise = pin_s & ~q.pin_q;
		next_q.north = pin_s;

		// register writes
		if (link.reg_wr) begin
			unique case (link.reg_addr)
				`ACS_OFS_ADC_CONTROL: next_q.adc_ctl = link.reg_wdata;
				`ACS_OFS_IO_CONTROL:  next_q.io_ctl  = link.reg_wdata;
				`ACS_OFS_FUNC_CONFIG: next_q.fn_cfg  = link.reg_wdata;
				`ACS_OFS_CONVERT: begin
					// only a one is taken, only while idle and pin low
					if (link.reg_wdata[`ACS_SOFT_START_BIT_SOFT_START] && q.st == ACS_IDLE && !pin_s) begin
						next_q.soft_start = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// sequencer
		unique case (q.st)
			ACS_IDLE: begin
				if (pin_rise || q.soft_start) begin
					next_q.done = 1'b0;
					if (q.adc_ctl[`ACS_ADC_POWER]) begin
						next_q.st  = ACS_OVERHEAD;
						next_q.cnt = CNT_W'(OVH_CYC - 1);
					end else begin
						next_q.st  = ACS_SETTLE;
						next_q.cnt = CNT_W'(SETTLE_CYCLES - 1);
					end
				end
			end
			ACS_SETTLE: begin
				next_q.cnt = q.cnt - 1'b1;
				if (q.cnt == '0) begin
					next_q.st  = ACS_OVERHEAD;
					next_q.cnt = CNT_W'(OVH_CYC - 1);
				end
			end
			ACS_OVERHEAD: begin
				next_q.cnt = q.cnt - 1'b1;
				if (q.cnt == '0) begin
					next_q.st  = ACS_CONVERT;
					next_q.pos = first_pos(4'h0, q.adc_ctl);
					next_q.cnt = CNT_W'(CH_CYC - 1);
				end
			end
			ACS_CONVERT: begin
				next_q.cnt = q.cnt - 1'b1;
				if (q.cnt == '0) begin
					k = 4'(pos_to_ch(q.pos));
					if (q.ch == `ACS_CH_TS1 || q.ch == `ACS_CH_TS2) begin
						next_q.res[k] = (adc_raw > `ACS_RES_MAX) ? 14'(`ACS_RES_MAX) : adc_raw[13:0];
					end else begin
						next_q.res[k] = adc_raw[13:0];
					end
					nxt = first_pos(q.pos + 4'h1, q.adc_ctl);
					if (nxt == `ACS_POS_NONE) begin
						next_q.st = ACS_IDLE;
						next_q.done = 1'b1;
						next_q.soft_start = 1'b0;
					end else begin
						next_q.pos = nxt;
						next_q.cnt = CNT_W'(CH_CYC - 1);
					end
				end
			end
		endcase

		// analog steering, registered toward the converter
		c = pos_to_ch(next_q.pos);
		next_q.ch = c;
		next_q.active = (next_q.st == ACS_CONVERT);
		next_q.aux_brick = next_q.fn_cfg[`ACS_FN_AUX_SOURCE];
		if (c == `ACS_CH_TS1 || c == `ACS_CH_TS2) begin
			next_q.ref_reg = 1'b1;
		end else if (c == `ACS_CH_AUX) begin
			// brick measurement always uses the bandgap
			next_q.ref_reg = ~next_q.fn_cfg[`ACS_FN_AUX_SOURCE]
				& ~next_q.fn_cfg[`ACS_FN_AUX_REF];
		end else begin
			next_q.ref_reg = 1'b0;
		end
		next_q.pwr = next_q.adc_ctl[`ACS_ADC_POWER] | (next_q.st != ACS_IDLE);
		next_q.done_out = next_q.done & north_done_s;

		// register reads, answered in the next cycle
		if (link.reg_rd) begin
			a = link.reg_addr;
			if (a >= `ACS_OFS_RESULT_BASE && a <= `ACS_OFS_RESULT_LAST) begin
				k = 4'((a - `ACS_OFS_RESULT_BASE) >> 1);
				next_q.rdata = a[0] ? {2'b00, q.res[k][13:8]} : q.res[k][7:0];
			end else begin
				unique case (a)
					`ACS_OFS_STATUS:      next_q.rdata = {6'h00, q.done, q.st != ACS_IDLE};
					`ACS_OFS_ADC_CONTROL: next_q.rdata = q.adc_ctl;
					`ACS_OFS_IO_CONTROL:  next_q.rdata = q.io_ctl;
					`ACS_OFS_FUNC_CONFIG: next_q.rdata = q.fn_cfg;
					`ACS_OFS_CONVERT:     next_q.rdata = {7'h00, q.soft_start};
					default:              next_q.rdata = '0;
				endcase
			end
		end
	end

	// ==========================================================
	// state register; clock enable freezes everything
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= next_q;
		end
	end

	// ==========================================================
	// outputs straight from the state register
	assign link.reg_rdata         = q.rdata;
	assign link.done_out_host_side = q.done_out;
	assign start_out_north        = q.north;
	assign adc_channel            = q.ch;
	assign adc_aux_brick          = q.aux_brick;
	assign adc_ref_regulator      = q.ref_reg;
	assign adc_active             = q.active;
	assign adc_power              = q.pwr;
	// switch bits pass straight out; software must pair them with enables
	assign thermistor_switch      = {q.io_ctl[`ACS_IO_TS2_SWITCH],
		q.io_ctl[`ACS_IO_TS1_SWITCH]};
endmodule : acs_device

// ---- hdl/acs_host.sv ----
/*
 * Host controller end: drives the start pin, waits for data-ready and
 * relays single register accesses to the monitor.
 * Assumes: software on a plain strobe port; monitor answers reads one
 * cycle after the strobe.
 */
`timescale 1ns/10ps
`include "acs_regs.svh"
module acs_host #(
	parameter int SETTLE_CYCLES =
		(`ACS_T_SETTLE_US * `ACS_NS_PER_US + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS,
	parameter int CNT_W         = 14
) (
	input  wire logic      clk,
	input  wire logic      rst_n,
	input  wire logic      ce,
	acs_link_if.host       link,
	input  wire acs_pkg::acs_byte_t addr,
	input  wire acs_pkg::acs_byte_t wdata,
	input  wire logic      wr,
	input  wire logic      rd,
	output acs_pkg::acs_byte_t rdata
);
	import acs_pkg::*;

	typedef struct packed {
		acs_pin_e         st;
		logic             req;
		logic             pin;
		logic             oe_n;
		acs_byte_t        dev_addr;
		acs_byte_t        dev_wdata;
		acs_byte_t        dev_rdata;
		logic             dwr;
		logic             drd;
		logic             cap;
		logic [CNT_W-1:0] wait_cnt;
		logic             pwr_ok;
		acs_byte_t        rdata;
	} acs_host_s;

	acs_host_s q;
	acs_host_s next_q;
	logic      done_s;

	// ==========================================================
	// data-ready pin synchroniser
	acs_sync3 u_done_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  (link.done_out_host_side),
		.dout (done_s)
	);

	// ==========================================================
	// next state
	always_comb begin
		next_q = q;
		next_q.rdata = '0;
		next_q.dwr = 1'b0;
		next_q.drd = 1'b0;
		next_q.cap = q.drd;
		if (q.cap) begin
			next_q.dev_rdata = link.reg_rdata;
		end
		if (q.wait_cnt != '0) begin
			next_q.wait_cnt = q.wait_cnt - 1'b1;
		end else begin
			next_q.pwr_ok = 1'b1;
		end

		if (wr) begin
			unique case (addr)
				`ACS_H_OFS_CTRL: begin
					next_q.dwr = wdata[`ACS_H_CTRL_DEV_WR];
					next_q.drd = wdata[`ACS_H_CTRL_DEV_RD] & ~wdata[`ACS_H_CTRL_DEV_WR];
					// reference warm-up after turning on manual mode
					if (wdata[`ACS_H_CTRL_DEV_WR] && q.dev_addr == `ACS_OFS_ADC_CONTROL
						&& q.dev_wdata[`ACS_ADC_POWER]) begin
						next_q.wait_cnt = CNT_W'(SETTLE_CYCLES);
						next_q.pwr_ok = 1'b0;
					end
				end
				`ACS_H_OFS_DEV_ADDR:  next_q.dev_addr  = wdata;
				`ACS_H_OFS_DEV_WDATA: next_q.dev_wdata = wdata;
				default: ;
			endcase
		end

		// pin sequence: released (pulled low) while idle, so soft starts work
		unique case (q.st)
			ACS_H_IDLE: begin
				next_q.pin = 1'b0;
				next_q.oe_n = 1'b1;
				if (q.req && q.pwr_ok) begin
					next_q.req = 1'b0;
					next_q.pin = 1'b1;
					next_q.oe_n = 1'b0;
					next_q.st = ACS_H_CLEAR;
				end
			end
			ACS_H_CLEAR: begin
				if (!done_s) begin
					next_q.st = ACS_H_WAIT;
				end
			end
			ACS_H_WAIT: begin
				// hold high through the cycle so no spurious edge restarts it
				if (done_s) begin
					next_q.pin = 1'b0;
					next_q.st = ACS_H_IDLE;
				end
			end
			default: next_q.st = ACS_H_IDLE;
		endcase

		// start request set after the take, so a new request in that cycle is kept
		if (wr && addr == `ACS_H_OFS_CTRL && wdata[`ACS_H_CTRL_HW_START]) begin
			next_q.req = 1'b1;
		end

		if (rd) begin
			unique case (addr)
				`ACS_H_OFS_CTRL:      next_q.rdata = {7'h00, q.req};
				`ACS_H_OFS_DEV_ADDR:  next_q.rdata = q.dev_addr;
				`ACS_H_OFS_DEV_WDATA: next_q.rdata = q.dev_wdata;
				`ACS_H_OFS_DEV_RDATA: next_q.rdata = q.dev_rdata;
				`ACS_H_OFS_STATUS:    next_q.rdata = {5'h00, q.pwr_ok, done_s, q.st != ACS_H_IDLE};
				default:              next_q.rdata = '0;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{st: ACS_H_IDLE, oe_n: 1'b1, pwr_ok: 1'b1, default: '0};
		end else if (ce) begin
			q <= next_q;
		end
	end

	assign link.host_start_out  = q.pin;
	assign link.host_start_oe_n = q.oe_n;
	assign link.reg_addr        = q.dev_addr;
	assign link.reg_wdata       = q.dev_wdata;
	assign link.reg_wr          = q.dwr;
	assign link.reg_rd          = q.drd;
	assign rdata                = q.rdata;
endmodule : acs_host

// ---- bench/acs_link_asserts.sv ----
/*
 * Checker for the host to monitor link: pin, data-ready and register port.
 * Assumes: instantiated beside acs_link_if, one clock, rst_n async low.
 */
`timescale 1ns/10ps
`include "acs_regs.svh"
module acs_link_asserts import acs_pkg::*; #(
	parameter int SETTLE_CYCLES =
		(`ACS_T_SETTLE_US * `ACS_NS_PER_US + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              host_start_oe_n,
	input wire logic              start_in_host_side,
	input wire logic              done_out_host_side,
	input wire acs_pkg::acs_byte_t reg_addr,
	input wire acs_pkg::acs_byte_t reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire acs_pkg::acs_byte_t reg_rdata
);
	import acs_pkg::*;
	localparam int CH = `ACS_T_CHANNEL_NS / `ACS_CLK_PERIOD_NS;
	logic        pin_q;
	logic [15:0] since_start;
	logic [15:0] since_power;

	// ==========================================================
	// helpers: cycles since pin start and since power-up write, saturating
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q       <= 1'b0;
			since_start <= 16'hffff;
			since_power <= 16'hffff;
		end else begin
			pin_q       <= start_in_host_side;
			since_start <= (start_in_host_side && !pin_q) ? 16'h0000 :
				since_start + 16'(since_start != 16'hffff);
			since_power <= (reg_wr && reg_addr == `ACS_OFS_ADC_CONTROL
				&& reg_wdata[`ACS_ADC_POWER]) ?
				16'h0000 : since_power + 16'(since_power != 16'hffff);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// sequences
	sequence s_pin_start;
		$rose(start_in_host_side);
	endsequence
	sequence s_msb_read;
		$past(reg_rd) && $past(reg_addr[0]) && $past(reg_addr) <= `ACS_OFS_RESULT_LAST;
	endsequence

	// ==========================================================
	// assertions
	a_pin_pulldown: assert property (
		host_start_oe_n |-> !start_in_host_side) else $error("pin high while released");
	a_pin_held: assert property (
		s_pin_start |-> start_in_host_side [*8]) else $error("start pin dropped early");
	a_pin_release: assert property (
		$fell(start_in_host_side) |-> done_out_host_side) else $error("pin dropped before done");
	a_done_clears: assert property (
		s_pin_start |-> ##[1:8] !done_out_host_side) else $error("done not cleared at start");
	a_done_not_early: assert property (
		$rose(done_out_host_side) |-> since_start >= 2 * CH) else $error("done too early");
	a_soft_pin_low: assert property (
		(reg_wr && reg_addr == `ACS_OFS_CONVERT && reg_wdata[0]) |-> !start_in_host_side)
		else $error("soft start with pin high");
	a_settle_wait: assert property (
		s_pin_start |-> since_power >= SETTLE_CYCLES - 1) else $error("start before settle");
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside its cycle");
	a_result_msb: assert property (
		s_msb_read |-> reg_rdata[7:6] == 2'b00) else $error("result msb top bits set");
endmodule : acs_link_asserts

// ---- bench/adc_conversion_sequencer_tb.sv ----
/*
 * Self-checking bench: host and monitor joined by the link, driven through
 * the host's software port.
 * Assumes: design files and the checker compiled before this file.
 */
`timescale 1ns/10ps
`include "acs_regs.svh"
module adc_conversion_sequencer_tb;
	import acs_pkg::*;
	localparam int SETTLE = 20;
	localparam int CH     = `ACS_T_CHANNEL_NS / `ACS_CLK_PERIOD_NS;
	logic       clk, rst_n, ce, wr, rd, done_in_north, north_seen, brick_seen;
	logic       start_out_north, adc_aux_brick, adc_ref_regulator, adc_active;
	logic       adc_power, act_q;
	logic [1:0] tsw;
	acs_byte_t  addr, wdata, rdata;
	acs_chan_t  adc_channel, ch_q;
	acs_raw_t   adc_raw;
	logic [4:0] seq[$];
	int         errors, checks_done, cyc, t_act, t0;

	acs_link_if lnk (.clk(clk));
	acs_host #(.SETTLE_CYCLES(SETTLE)) i_acs_host (.clk(clk), .rst_n(rst_n), .ce(ce),
		.link(lnk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	acs_device #(.SETTLE_CYCLES(SETTLE)) i_acs_device (.clk(clk), .rst_n(rst_n), .ce(ce),
		.link(lnk), .start_out_north(start_out_north), .done_in_north(done_in_north),
		.adc_channel(adc_channel), .adc_aux_brick(adc_aux_brick),
		.adc_ref_regulator(adc_ref_regulator), .adc_active(adc_active),
		.adc_power(adc_power), .thermistor_switch(tsw), .adc_raw(adc_raw));
	acs_link_asserts #(.SETTLE_CYCLES(SETTLE)) i_acs_link_asserts (.clk(clk), .rst_n(rst_n),
		.host_start_oe_n(lnk.host_start_oe_n), .start_in_host_side(lnk.start_in_host_side),
		.done_out_host_side(lnk.done_out_host_side), .reg_addr(lnk.reg_addr),
		.reg_wdata(lnk.reg_wdata), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
		.reg_rdata(lnk.reg_rdata));

	// ==========================================================
	// clock, converter stand-in and channel monitor
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// distinct raw per channel; ts1 over range to hit the clamp
	function automatic acs_raw_t raw_of(input acs_chan_t c);
		case (c)
			`ACS_CH_TS1: raw_of = 16'hffff;
			`ACS_CH_TS2: raw_of = 16'h0123;
			`ACS_CH_AUX: raw_of = 16'hc234;
			default:     raw_of = 16'h1000 + 16'(c);
		endcase
	endfunction : raw_of
	always @(posedge clk) begin
		cyc     <= cyc + 1;
		act_q   <= adc_active;
		ch_q    <= adc_channel;
		adc_raw <= raw_of(adc_channel);
		if (adc_active && (!act_q || adc_channel != ch_q)) begin
			seq.push_back({adc_ref_regulator, adc_channel});
			if (t_act == 0) t_act <= cyc;
		end
		if (start_out_north) north_seen <= 1'b1;
		if (adc_active && adc_channel == `ACS_CH_AUX && adc_aux_brick) brick_seen <= 1'b1;
	end

	// ==========================================================
	// checking and bus tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic hw(input acs_byte_t a, input acs_byte_t d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		@(posedge clk);
	endtask : hw
	task automatic hr(input acs_byte_t a, input acs_byte_t e);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 chk(16'(rdata), 16'(e));
		@(posedge clk);
	endtask : hr
	// relayed monitor accesses
	task automatic dw(input acs_byte_t a, input acs_byte_t d);
		hw(`ACS_H_OFS_DEV_ADDR, a);
		hw(`ACS_H_OFS_DEV_WDATA, d);
		hw(`ACS_H_OFS_CTRL, 8'h02);
		repeat (4) @(posedge clk);
	endtask : dw
	task automatic dr(input acs_byte_t a, input acs_byte_t e);
		hw(`ACS_H_OFS_DEV_ADDR, a);
		hw(`ACS_H_OFS_CTRL, 8'h04);
		repeat (4) @(posedge clk);
		hr(`ACS_H_OFS_DEV_RDATA, e);
	endtask : dr
	task automatic wait_done;
		int n;
		n = 0;
		while (lnk.done_out_host_side !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		chk(16'(n < 5000), 16'h0001);
	endtask : wait_done
	task automatic chk_seq(input logic [4:0] e[$]);
		chk(16'(seq.size()), 16'(e.size()));
		foreach (e[i]) chk(16'(seq[i]), 16'(e[i]));
		seq.delete();
	endtask : chk_seq
	task automatic report_and_stop;
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// watchdog: whole run is a few thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		report_and_stop();
	end

	// ==========================================================
	// main sequence
	initial begin
		{rst_n, wr, rd, addr, wdata, north_seen, brick_seen, act_q, ch_q} = '0;
		{ce, done_in_north} = 2'b11;
		adc_raw = 16'h0000;
		cyc = 0;
		t_act = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// manual mode, pin start, two cells plus every extra channel
		dw(`ACS_OFS_FUNC_CONFIG, 8'h00);
		dw(`ACS_OFS_IO_CONTROL, 8'h03);
		chk(16'(tsw), 16'h0003);
		dw(`ACS_OFS_ADC_CONTROL, 8'h79);
		chk(16'(adc_power), 16'h0001);
		hw(`ACS_H_OFS_CTRL, 8'h01);
		wait_done();
		chk(16'(north_seen), 16'h0001);
		chk(16'(brick_seen), 16'h0000);
		chk_seq('{5'h01, 5'h02, 5'h17, 5'h18, 5'h10});
		dr(8'h01, 8'h02);
		dr(8'h02, 8'h34);
		dr(8'h03, 8'h10);
		dr(8'h04, 8'h01);
		dr(8'h0f, 8'h3f);
		dr(8'h10, 8'hff);
		dr(8'h11, 8'h01);
		// soft start, brick source with bandgap forced, six cells, a second start ignored
		dw(`ACS_OFS_FUNC_CONFIG, 8'h10);
		dw(`ACS_OFS_IO_CONTROL, 8'h00);
		chk(16'(tsw), 16'h0000);
		dw(`ACS_OFS_ADC_CONTROL, 8'h4d);
		dw(`ACS_OFS_CONVERT, 8'h01);
		dr(`ACS_OFS_CONVERT, 8'h01);
		dw(`ACS_OFS_CONVERT, 8'h01);
		hw(`ACS_H_OFS_CTRL, 8'h01);
		wait_done();
		chk(16'(brick_seen), 16'h0001);
		chk_seq('{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00});
		dr(`ACS_OFS_CONVERT, 8'h00);
		// automatic mode, zero write refused, done held back by the north device
		dw(`ACS_OFS_ADC_CONTROL, 8'h00);
		dw(`ACS_OFS_CONVERT, 8'h00);
		repeat (20) @(posedge clk);
		chk(16'(lnk.done_out_host_side), 16'h0001);
		chk(16'(seq.size()), 16'h0000);
		// done is a level gated by north, so drop north only once the refusal is checked
		done_in_north <= 1'b0;
		t0 = cyc;
		t_act = 0;
		dw(`ACS_OFS_CONVERT, 8'h01);
		repeat (SETTLE + 2 * CH + 40) @(posedge clk);
		chk(16'(lnk.done_out_host_side), 16'h0000);
		chk(16'(t_act - t0 >= SETTLE + CH), 16'h0001);
		done_in_north <= 1'b1;
		repeat (8) @(posedge clk);
		chk(16'(lnk.done_out_host_side), 16'h0001);
		chk_seq('{5'h01});
		// unmapped places read as zero
		dr(8'h20, 8'h00);
		hr(8'h10, 8'h00);
		report_and_stop();
	end
endmodule : adc_conversion_sequencer_tb
